// File: design/mcc_apb_slave.sv
// apb slave for the single configuration word
`timescale 1ns/10ps
`include "mcc_params.svh"
module mcc_apb_slave (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // apb
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [15:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // register side
    mcc_reg_if.bus           reg_bus
);
    logic [31:0] prdata_q;
    wire         addr_hit = (paddr_i == `MCC_CFG_ADDR);
    wire         setup    = psel_i & ~penable_i;
    wire         access   = psel_i & penable_i;

    // ========================================================
    // zero wait states; read data sampled in setup phase
    assign pready_o      = 1'b1;
    assign pslverr_o     = access & ~addr_hit;
    assign prdata_o      = prdata_q;
    assign reg_bus.wr_en = access & pwrite_i & addr_hit;
    assign reg_bus.wdata = pwdata_i[15:0];

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            prdata_q <= 32'h0;
        end else if (setup) begin
            prdata_q <= addr_hit ? {16'h0, reg_bus.rdata} : 32'h0;
        end
    end
endmodule

// File: design/mcc_config_top.sv
// metering core configuration register and the routing it steers
`timescale 1ns/10ps
`include "mcc_params.svh"
module mcc_config_top #(
    parameter int unsigned SETTLE_SHORT_CYC =
        `MCC_SETTLE_SHORT_MS * 1000 * `MCC_CLK_MHZ,
    parameter int unsigned SETTLE_LONG_CYC =
        `MCC_SETTLE_LONG_MS * 1000 * `MCC_CLK_MHZ
) (
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    // apb
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [15:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // sources for the shared pins
    input  wire logic                 sample_ready_output_i,
    input  wire logic [2:0]           zero_crossing_output_i,
    input  wire logic                 fast_serial_clock_i,
    input  wire logic                 third_energy_pulse_i,
    // channel samples, index 0..3 = a, b, c, neutral
    input  wire mcc_pkg::mcc_quad_t   volt_chan_i,
    input  wire mcc_pkg::mcc_quad_t   curr_chan_i,
    // shared pins
    output logic                      shared_pin_o,
    output logic                      energy_pin_o,
    // channel results
    output mcc_pkg::mcc_quad_t        volt_result_o,
    output mcc_pkg::mcc_quad_t        curr_result_o,
    output mcc_pkg::mcc_sample_t      pair_volt_a_o,
    output mcc_pkg::mcc_sample_t      pair_volt_b_o,
    output mcc_pkg::mcc_sample_t      pair_volt_c_o,
    output mcc_pkg::mcc_wide_t        neutral_rms_input_o,
    // datapath controls
    output logic                      highpass_filter_on_o,
    output logic                      power_lowpass_settle_select_o,
    output logic      [31:0]          lpf_settle_cycles_o,
    output logic                      fast_serial_port_on_o,
    output logic                      soft_reset_o
);
    import mcc_pkg::*;

    mcc_reg_if reg_bus ();

    // ========================================================
    // bus slave
    mcc_apb_slave u_apb (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .reg_bus   (reg_bus.bus)
    );

    // ========================================================
    // configuration word and soft reset sequencer
    logic [15:0]     cfg_q;
    logic [15:0]     cfg_d;
    mcc_srst_state_t srst_state_q;
    mcc_srst_state_t srst_state_d;
    logic [3:0]      srst_cnt_q;
    logic [3:0]      srst_cnt_d;

    wire        cfg_wr     = reg_bus.wr_en;
    wire        srst_start = cfg_wr & reg_bus.wdata[`MCC_SRST_BIT];
    wire        srst_busy  = (srst_state_q == MCC_SRST_BUSY);
    wire        srst_done  = srst_busy & (srst_cnt_q == 4'h0);

    // fields go back to defaults for the whole pulse; writes of other
    // fields during the pulse are dropped, a new trigger restarts it
    assign cfg_d = (srst_start | srst_busy) ? `MCC_CFG_RESET
                 : cfg_wr ? (reg_bus.wdata & `MCC_CFG_WR_MASK)
                 : cfg_q;

    // a trigger in the last cycle wins over the self clear
    always_comb begin
        srst_state_d = srst_state_q;
        srst_cnt_d   = srst_cnt_q;
        unique case (srst_state_q)
            MCC_SRST_IDLE: begin
                if (srst_start) begin
                    srst_state_d = MCC_SRST_BUSY;
                    srst_cnt_d   = `MCC_SRST_LAST;
                end
            end
            MCC_SRST_BUSY: begin
                if (srst_start) begin
                    srst_cnt_d = `MCC_SRST_LAST;
                end else if (srst_done) begin
                    srst_state_d = MCC_SRST_IDLE;
                end else begin
                    srst_cnt_d = srst_cnt_q - 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cfg_q        <= `MCC_CFG_RESET;
            srst_state_q <= MCC_SRST_IDLE;
            srst_cnt_q   <= 4'h0;
        end else begin
            cfg_q        <= cfg_d;
            srst_state_q <= srst_state_d;
            srst_cnt_q   <= srst_cnt_d;
        end
    end

    // reserved bits 2 and 15 read zero; bit 7 shows the pulse
    wire [15:0] cfg_rd = (cfg_q & `MCC_CFG_WR_MASK)
                       | {8'h0, srst_busy, 7'h0};
    assign reg_bus.rdata = cfg_rd;
    assign soft_reset_o  = srst_busy;

    // ========================================================
    // field decode
    wire [1:0] pin_fn   = cfg_q[`MCC_PIN_FN_HI:`MCC_PIN_FN_LO];
    wire       swap_on  = cfg_q[`MCC_SWAP_BIT];
    wire       lpf_long = cfg_q[`MCC_LPF_BIT];
    wire       fsp_on   = cfg_q[`MCC_FSP_BIT];
    wire [1:0] pair_a   = cfg_q[`MCC_PAIR_A_HI:`MCC_PAIR_A_LO];
    wire [1:0] pair_b   = cfg_q[`MCC_PAIR_B_HI:`MCC_PAIR_B_LO];
    wire [1:0] pair_c   = cfg_q[`MCC_PAIR_C_HI:`MCC_PAIR_C_LO];
    wire       nsel_sum = cfg_q[`MCC_NSEL_BIT];

    // ========================================================
    // shared pin selection
    logic shared_pin_d;
    always_comb begin
        unique case (mcc_pin_fn_t'(pin_fn))
            MCC_PIN_READY: shared_pin_d = sample_ready_output_i;
            MCC_PIN_ZX_A:  shared_pin_d = zero_crossing_output_i[0];
            MCC_PIN_ZX_B:  shared_pin_d = zero_crossing_output_i[1];
            MCC_PIN_ZX_C:  shared_pin_d = zero_crossing_output_i[2];
        endcase
    end

    wire energy_pin_d = fsp_on ? fast_serial_clock_i
                               : third_energy_pulse_i;

    // ========================================================
    // channel swap, pairing and neutral source
    wire mcc_quad_t vres = swap_on ? curr_chan_i : volt_chan_i;
    wire mcc_quad_t ires = swap_on ? volt_chan_i : curr_chan_i;

    mcc_sample_t pair_a_v;
    mcc_sample_t pair_b_v;
    mcc_sample_t pair_c_v;

    mcc_pair_mux #(.BASE(2'h0)) u_pair_a (
        .code_i (pair_a),
        .volt_i (vres),
        .volt_o (pair_a_v)
    );
    mcc_pair_mux #(.BASE(2'h1)) u_pair_b (
        .code_i (pair_b),
        .volt_i (vres),
        .volt_o (pair_b_v)
    );
    mcc_pair_mux #(.BASE(2'h2)) u_pair_c (
        .code_i (pair_c),
        .volt_i (vres),
        .volt_o (pair_c_v)
    );

    // signed sum of three phases needs two guard bits
    wire mcc_wide_t phase_current_sum = {{2{ires[0][23]}}, ires[0]}
                         + {{2{ires[1][23]}}, ires[1]}
                         + {{2{ires[2][23]}}, ires[2]};
    wire mcc_wide_t ineu = {{2{ires[3][23]}}, ires[3]};
    wire mcc_wide_t nsrc = nsel_sum ? phase_current_sum : ineu;

    wire [31:0] settle_d = lpf_long ? 32'(SETTLE_LONG_CYC)
                                    : 32'(SETTLE_SHORT_CYC);

    // ========================================================
    // output registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            shared_pin_o        <= 1'b0;
            energy_pin_o        <= 1'b0;
            volt_result_o       <= '0;
            curr_result_o       <= '0;
            pair_volt_a_o       <= '0;
            pair_volt_b_o       <= '0;
            pair_volt_c_o       <= '0;
            neutral_rms_input_o <= '0;
            lpf_settle_cycles_o <= 32'(SETTLE_SHORT_CYC);
        end else begin
            shared_pin_o        <= shared_pin_d;
            energy_pin_o        <= energy_pin_d;
            volt_result_o       <= vres;
            curr_result_o       <= ires;
            pair_volt_a_o       <= pair_a_v;
            pair_volt_b_o       <= pair_b_v;
            pair_volt_c_o       <= pair_c_v;
            neutral_rms_input_o <= nsrc;
            lpf_settle_cycles_o <= settle_d;
        end
    end

    assign highpass_filter_on_o          = cfg_q[`MCC_HPF_BIT];
    assign power_lowpass_settle_select_o = lpf_long;
    assign fast_serial_port_on_o         = fsp_on;

    // ========================================================
    // checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    wire apb_rd_done = psel_i & penable_i & pready_o & ~pwrite_i
                     & (paddr_i == `MCC_CFG_ADDR);
    wire apb_wr_cfg  = psel_i & penable_i & pwrite_i
                     & (paddr_i == `MCC_CFG_ADDR);

    a_pin_ready: assert property (
        (pin_fn == 2'h0) |=> (shared_pin_o == $past(sample_ready_output_i))
    ) else $error("shared pin not carrying sample ready");

    a_pin_zx_a: assert property (
        (pin_fn == 2'h1)
        |=> (shared_pin_o == $past(zero_crossing_output_i[0]))
    ) else $error("shared pin not carrying phase a crossing");

    a_pin_zx_c: assert property (
        (pin_fn == 2'h3)
        |=> (shared_pin_o == $past(zero_crossing_output_i[2]))
    ) else $error("shared pin not carrying phase c crossing");

    a_swap_off: assert property (
        !swap_on |=> (volt_result_o == $past(volt_chan_i)
                      && curr_result_o == $past(curr_chan_i))
    ) else $error("channels exchanged without swap");

    a_hpf_srst: assert property (
        srst_busy |-> highpass_filter_on_o
    ) else $error("high-pass not back on during soft reset");

    a_lpf_short: assert property (
        (!lpf_long)[*2] |-> (lpf_settle_cycles_o == 32'(SETTLE_SHORT_CYC))
    ) else $error("short settle time not selected");

    a_serial_clk: assert property (
        fsp_on |=> (energy_pin_o == $past(fast_serial_clock_i))
    ) else $error("serial clock not on shared pin");

    a_pair_a_sel: assert property (
        (pair_a == 2'h1) |=> (pair_volt_a_o == $past(vres[1]))
    ) else $error("phase a not paired with phase b voltage");

    a_pair_b_rsv: assert property (
        (pair_b == 2'h3) |=> (pair_volt_b_o == $past(vres[1]))
    ) else $error("phase b reserved pairing not own voltage");

    a_pair_c_rsv: assert property (
        (pair_c == 2'h3) |=> (pair_volt_c_o == $past(vres[2]))
    ) else $error("phase c reserved pairing not own voltage");

    a_neutral_own: assert property (
        !nsel_sum |=> (neutral_rms_input_o
                       == $past({{2{ires[3][23]}}, ires[3]}))
    ) else $error("neutral source not the neutral current");

    a_pin_zx_b: assert property (
        (pin_fn == 2'h2)
        |=> (shared_pin_o == $past(zero_crossing_output_i[1]))
    ) else $error("shared pin not carrying phase b crossing");

    a_rsv_read: assert property (
        apb_rd_done |-> (prdata_o[2] == 1'b0 && prdata_o[31:16] == 16'h0)
    ) else $error("reserved bits read nonzero");

    a_swap_route: assert property (
        swap_on |=> (volt_result_o == $past(curr_chan_i)
                     && curr_result_o == $past(volt_chan_i))
    ) else $error("swapped channels not exchanged");

    a_hpf_write: assert property (
        (apb_wr_cfg && !srst_busy && !pwdata_i[`MCC_SRST_BIT])
        |=> (highpass_filter_on_o == $past(pwdata_i[`MCC_HPF_BIT]))
    ) else $error("high-pass enable did not follow write");

    a_lpf_settle: assert property (
        lpf_long[*2] |-> (lpf_settle_cycles_o == 32'(SETTLE_LONG_CYC))
    ) else $error("long settle time not selected");

    a_serial_pin: assert property (
        !fsp_on |=> (energy_pin_o == $past(third_energy_pulse_i))
    ) else $error("energy pulse not on shared pin");

    a_srst_pulse: assert property (
        apb_wr_cfg && pwdata_i[`MCC_SRST_BIT]
        |=> soft_reset_o[*8] ##1 (cfg_q == `MCC_CFG_RESET)
    ) else $error("soft reset pulse too short");

    a_pair_a_rsv: assert property (
        (pair_a == 2'h3) |=> (pair_volt_a_o == $past(vres[0]))
    ) else $error("phase a reserved pairing not own voltage");

    a_pair_b_sel: assert property (
        (pair_b == 2'h1) |=> (pair_volt_b_o == $past(vres[2]))
    ) else $error("phase b not paired with phase c voltage");

    a_pair_c_sel: assert property (
        (pair_c == 2'h2) |=> (pair_volt_c_o == $past(vres[1]))
    ) else $error("phase c not paired with phase b voltage");

    a_neutral_sum: assert property (
        nsel_sum |=> (neutral_rms_input_o == $past(phase_current_sum))
    ) else $error("neutral source not the phase sum");

    a_bit15_inert: assert property (
        apb_wr_cfg |=> (cfg_q[15] == 1'b0)
    ) else $error("reserved top bit stored");

    a_srst_clear: assert property (
        (srst_done && !srst_start)
        |=> (!soft_reset_o && cfg_rd[`MCC_SRST_BIT] == 1'b0)
    ) else $error("soft reset bit did not self clear");

    // counts pulse cycles so the full length can be checked
    logic [4:0] srst_age_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || srst_start) begin
            srst_age_q <= 5'h00;
        end else if (srst_busy) begin
            srst_age_q <= srst_age_q + 5'h01;
        end
    end

    a_srst_length: assert property (
        (srst_done && !srst_start) |-> (srst_age_q == {1'b0, `MCC_SRST_LAST})
    ) else $error("soft reset pulse not sixteen cycles");
endmodule

// File: design/mcc_pair_mux.sv
// picks the phase voltage paired with one phase current
`timescale 1ns/10ps
module mcc_pair_mux #(
    parameter logic [1:0] BASE = 2'h0
) (
    // selection
    input  wire logic [1:0]         code_i,
    input  wire mcc_pkg::mcc_quad_t volt_i,
    // result
    output mcc_pkg::mcc_sample_t    volt_o
);
    import mcc_pkg::*;

    // reserved code 11 falls back to the phase's own voltage
    wire [2:0] sum = {1'b0, BASE} + {1'b0, code_i};
    wire [2:0] wrap = (sum >= 3'h3) ? sum - 3'h3 : sum;
    wire [1:0] idx = (code_i == 2'h3) ? BASE : wrap[1:0];

    assign volt_o = volt_i[idx];
endmodule

// File: design/mcc_params.svh
// constants for the metering core configuration register block
`ifndef MCC_PARAMS_SVH
`define MCC_PARAMS_SVH

// ========================================================
// register map
`define MCC_CFG_ADDR        16'he618
`define MCC_CFG_RESET       16'h0010
// bits 2, 7 and 15 are not stored
`define MCC_CFG_WR_MASK     16'h7f7b

// ========================================================
// field positions
`define MCC_PIN_FN_LO       0
`define MCC_PIN_FN_HI       1
`define MCC_SWAP_BIT        3
`define MCC_HPF_BIT         4
`define MCC_LPF_BIT         5
`define MCC_FSP_BIT         6
`define MCC_SRST_BIT        7
`define MCC_PAIR_A_LO       8
`define MCC_PAIR_A_HI       9
`define MCC_PAIR_B_LO       10
`define MCC_PAIR_B_HI       11
`define MCC_PAIR_C_LO       12
`define MCC_PAIR_C_HI       13
`define MCC_NSEL_BIT        14

// ========================================================
// timing
`define MCC_CLK_MHZ         100
`define MCC_SETTLE_SHORT_MS 650
`define MCC_SETTLE_LONG_MS  1300
// soft reset pulse is 16 cycles: counter loads length minus one
`define MCC_SRST_LAST       4'hf

`endif

// File: design/mcc_pkg.sv
// types shared by the configuration register block
package mcc_pkg;

    typedef logic [23:0]       mcc_sample_t;
    typedef logic [3:0][23:0]  mcc_quad_t;
    typedef logic [25:0]       mcc_wide_t;

    typedef enum logic [1:0] {
        MCC_PIN_READY,
        MCC_PIN_ZX_A,
        MCC_PIN_ZX_B,
        MCC_PIN_ZX_C
    } mcc_pin_fn_t;

    typedef enum logic {
        MCC_SRST_IDLE,
        MCC_SRST_BUSY
    } mcc_srst_state_t;

endpackage

// File: design/mcc_reg_if.sv
// register access path between bus slave and configuration core
`timescale 1ns/10ps
interface mcc_reg_if;
    logic        wr_en;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport bus  (output wr_en, output wdata, input rdata);
    modport core (input wr_en, input wdata, output rdata);
endinterface

// File: verification/test_mcc_config_top.sv
// self-checking bench for the configuration register block
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module test_mcc_config_top;
    import mcc_pkg::*;

    // ========================================================
    // constants and signals
    // shortened settling counts keep the run brief
    localparam int unsigned SHORT    = 65;
    localparam int unsigned LONG     = 130;
    localparam logic [15:0] CFG      = 16'he618;
    localparam logic [15:0] NOWHERE  = 16'he61c;

    logic          sys_clk;
    logic          rst;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [15:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata_o;
    logic          pready_o;
    logic          pslverr_o;
    logic          ready_src;
    logic [2:0]    zx_src;
    logic          fclk_src;
    logic          pulse_src;
    mcc_quad_t     volt_in;
    mcc_quad_t     curr_in;
    logic          shared_pin_o;
    logic          energy_pin_o;
    mcc_quad_t     volt_result_o;
    mcc_quad_t     curr_result_o;
    mcc_sample_t   pair_a;
    mcc_sample_t   pair_b;
    mcc_sample_t   pair_c;
    mcc_wide_t     neutral_o;
    logic          hpf_on_o;
    logic          lpf_sel_o;
    logic [31:0]   lpf_cyc_o;
    logic          fsp_on_o;
    logic          soft_reset_o;
    logic          last_err;
    mcc_sample_t   got;
    int            err_count;
    int            cmp_count;
    int            cyc;
    int            c;
    int            v;
    int            f;
    int            n;

    mcc_config_top #(
        .SETTLE_SHORT_CYC(SHORT),
        .SETTLE_LONG_CYC (LONG)
    ) i_dut (
        .sys_clk_i                    (sys_clk),
        .rst_i                        (rst),
        .psel_i                       (psel),
        .penable_i                    (penable),
        .pwrite_i                     (pwrite),
        .paddr_i                      (paddr),
        .pwdata_i                     (pwdata),
        .prdata_o                     (prdata_o),
        .pready_o                     (pready_o),
        .pslverr_o                    (pslverr_o),
        .sample_ready_output_i        (ready_src),
        .zero_crossing_output_i       (zx_src),
        .fast_serial_clock_i          (fclk_src),
        .third_energy_pulse_i         (pulse_src),
        .volt_chan_i                  (volt_in),
        .curr_chan_i                  (curr_in),
        .shared_pin_o                 (shared_pin_o),
        .energy_pin_o                 (energy_pin_o),
        .volt_result_o                (volt_result_o),
        .curr_result_o                (curr_result_o),
        .pair_volt_a_o                (pair_a),
        .pair_volt_b_o                (pair_b),
        .pair_volt_c_o                (pair_c),
        .neutral_rms_input_o          (neutral_o),
        .highpass_filter_on_o         (hpf_on_o),
        .power_lowpass_settle_select_o(lpf_sel_o),
        .lpf_settle_cycles_o          (lpf_cyc_o),
        .fast_serial_port_on_o        (fsp_on_o),
        .soft_reset_o                 (soft_reset_o)
    );

    // ========================================================
    // clock, timeout, verdict
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // whole run needs about 220 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // ========================================================
    // bus tasks
    task automatic apb(input logic [15:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready_o !== 1'b1);
        rd       = prdata_o;
        last_err = pslverr_o;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [31:0] rd;
        apb(a, 1'b1, {16'h0000, d}, rd);
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp,
                         input logic exp_err);
        logic [31:0] rd;
        apb(a, 1'b0, 32'h0000_0000, rd);
        `CHK(rd, exp)
        `CHK(last_err, exp_err)
    endtask

    // registered outputs follow a write one cycle later
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    function automatic mcc_wide_t sx(input mcc_sample_t s);
        return {{2{s[23]}}, s};
    endfunction

    // ========================================================
    // main sequence
    initial begin
        rst       = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 16'h0000;
        pwdata    = 32'h0000_0000;
        ready_src = 1'b0;
        zx_src    = 3'h0;
        fclk_src  = 1'b0;
        pulse_src = 1'b0;
        volt_in   = {24'h111111, 24'h222222, 24'h333333, 24'h444444};
        curr_in   = {24'hc00001, 24'h400000, 24'h7fffff, 24'h800000};
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        `CHK(hpf_on_o, 1'b1)
        `CHK(lpf_cyc_o, SHORT)
        rdchk(CFG, 32'h0000_0010, 1'b0);
        // each pin code, each level, other sources opposite
        for (c = 0; c < 4; c++) begin
            for (v = 0; v < 2; v++) begin
                wr(CFG, 16'(c));
                ready_src <= (c == 0) ? v[0] : ~v[0];
                zx_src    <= (c == 0) ? {3{~v[0]}}
                           : ({3{~v[0]}} ^ (3'h1 << (c - 1)));
                settle();
                `CHK(shared_pin_o, v[0])
            end
        end
        // every writable bit set; soft reset bit left clear
        wr(CFG, 16'hff7f);
        fclk_src  <= 1'b1;
        pulse_src <= 1'b0;
        settle();
        rdchk(CFG, 32'h0000_7f7b, 1'b0);
        `CHK(hpf_on_o, 1'b1)
        `CHK(lpf_sel_o, 1'b1)
        `CHK(lpf_cyc_o, LONG)
        `CHK(fsp_on_o, 1'b1)
        `CHK(energy_pin_o, 1'b1)
        wr(CFG, 16'h0000);
        fclk_src  <= 1'b0;
        pulse_src <= 1'b1;
        settle();
        `CHK(hpf_on_o, 1'b0)
        `CHK(lpf_cyc_o, SHORT)
        `CHK(fsp_on_o, 1'b0)
        `CHK(energy_pin_o, 1'b1)
        `CHK(volt_result_o, volt_in)
        `CHK(curr_result_o, curr_in)
        `CHK(neutral_o, sx(curr_in[3]))
        // bit 15 rides along and must change nothing
        wr(CFG, 16'hc008);
        settle();
        `CHK(volt_result_o, curr_in)
        `CHK(curr_result_o, volt_in)
        `CHK(neutral_o, sx(volt_in[0]) + sx(volt_in[1]) + sx(volt_in[2]))
        wr(CFG, 16'h4000);
        settle();
        `CHK(neutral_o, sx(curr_in[0]) + sx(curr_in[1]) + sx(curr_in[2]))
        // voltage pairing, all three fields, all four codes
        for (f = 0; f < 3; f++) begin
            for (c = 0; c < 4; c++) begin
                wr(CFG, 16'(c) << (8 + 2 * f));
                settle();
                got = (f == 0) ? pair_a : (f == 1) ? pair_b : pair_c;
                `CHK(got, volt_in[(f + ((c == 3) ? 0 : c)) % 3])
            end
        end
        // soft reset: pulse length, then self-clearing bit
        wr(CFG, 16'h0020);
        wr(CFG, 16'h0080);
        n = 0;
        #1;
        while (soft_reset_o === 1'b1 && n < 40) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        `CHK(n, 16)
        rdchk(CFG, 32'h0000_0010, 1'b0);
        // busy bit visible while the pulse runs; writes dropped
        wr(CFG, 16'h0080);
        rdchk(CFG, 32'h0000_0090, 1'b0);
        wr(CFG, 16'h0020);
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK(soft_reset_o, 1'b0)
        rdchk(CFG, 32'h0000_0010, 1'b0);
        // unmapped word refuses both directions
        wr(NOWHERE, 16'h0020);
        `CHK(last_err, 1'b1)
        rdchk(NOWHERE, 32'h0000_0000, 1'b1);
        rdchk(CFG, 32'h0000_0010, 1'b0);
        give_verdict();
    end
endmodule
